// >>> bix_exec.sv
// Executes the unconditional branch and file increment instructions.
// Assumes fetch presents one instruction per cycle with insn_valid, and the
// register file gives read data combinationally for file_raddr.
// Overview of operation
// - A branch loads its eleven-bit literal into program counter bits 10 to 0.
// - A branch fills program counter bits 12 and 11 from latch bits 4 and 3.
// - A branch takes two cycles, the second being a no-op flush cycle.
// - An increment reads the file register and adds one, wrapping to zero.
// - With the destination bit 0 the sum goes to the working register only.
// - With the destination bit 1 the sum goes back into the file register.
`timescale 1ns/1ps
`default_nettype none
module bix_exec #(
    parameter int DATA_W = bix_pkg::DATA_W
) (
    input wire logic sys_clk, // Core clock
    input wire logic arst_n, // Async reset, active low
    input wire logic insn_valid, // Instruction word valid
    input wire logic [bix_pkg::INSN_W-1:0] insn, // Instruction word
    input wire logic [7:0] program_counter_high_latch, // High latch register
    input wire logic [DATA_W-1:0] file_rdata, // File register read data
    output logic [bix_pkg::FADDR_W-1:0] file_raddr, // File register address
    output logic file_we, // File write strobe
    output logic [bix_pkg::FADDR_W-1:0] file_waddr, // File write address
    output logic [DATA_W-1:0] file_wdata, // File write data
    output logic wreg_we, // Working register write strobe
    output logic [DATA_W-1:0] wreg_wdata, // Working register data
    output logic zero_we, // Zero flag write strobe
    output logic zero_flag, // Zero flag value
    output logic pc_load, // Program counter load strobe
    output logic [bix_pkg::PC_W-1:0] pc_target, // New program counter
    output logic flush // Pipeline refill cycle
);
    bix_pkg::bix_state_t state_q, state_d;
    logic [bix_pkg::PC_W-1:0] pc_q, pc_d;
    logic pc_load_q, pc_load_d;
    logic inc_q, inc_d;
    logic dest_q, dest_d;
    logic [bix_pkg::FADDR_W-1:0] addr_q, addr_d;
    logic is_branch, is_inc, take;
    logic [DATA_W-1:0] sum;
    logic sum_zero;

    if (DATA_W != bix_pkg::DATA_W) begin : g_width_check
        $error("bix_exec: DATA_W must match package");
    end

    assign take = insn_valid && (state_q == bix_pkg::BIX_EXEC);
    assign is_branch = take &&
        (insn[bix_pkg::BRANCH_OPC_MSB:bix_pkg::BRANCH_OPC_LSB] == bix_pkg::BRANCH_OPC);
    assign is_inc = take &&
        (insn[bix_pkg::INC_OPC_MSB:bix_pkg::INC_OPC_LSB] == bix_pkg::INC_OPC);
    assign file_raddr = insn[bix_pkg::FADDR_W-1:0];

    bix_incr #(.WIDTH(DATA_W)) u_incr (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .load(is_inc),
        .operand(file_rdata),
        .sum(sum),
        .zero(sum_zero)
    );

    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        pc_load_d = 1'b0;
        inc_d = is_inc;
        dest_d = dest_q;
        addr_d = addr_q;
        unique case (state_q)
            bix_pkg::BIX_EXEC: begin
                if (is_branch) begin
                    pc_d = {program_counter_high_latch[bix_pkg::LATCH_HI_MSB:
                            bix_pkg::LATCH_HI_LSB],
                            insn[bix_pkg::LIT_W-1:0]};
                    pc_load_d = 1'b1;
                    state_d = bix_pkg::BIX_FLUSH;
                end
                if (is_inc) begin
                    dest_d = insn[bix_pkg::INC_DEST_BIT];
                    addr_d = insn[bix_pkg::FADDR_W-1:0];
                end
            end
            bix_pkg::BIX_FLUSH: begin
                state_d = bix_pkg::BIX_EXEC;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= bix_pkg::BIX_EXEC;
            pc_q <= bix_pkg::PC_RESET;
            pc_load_q <= 1'b0;
            inc_q <= 1'b0;
            dest_q <= bix_pkg::DEST_WREG;
            addr_q <= '0;
        end else begin
            state_q <= state_d;
            pc_q <= pc_d;
            pc_load_q <= pc_load_d;
            inc_q <= inc_d;
            dest_q <= dest_d;
            addr_q <= addr_d;
        end
    end

    assign pc_load = pc_load_q;
    assign pc_target = pc_q;
    assign flush = (state_q == bix_pkg::BIX_FLUSH);
    assign wreg_we = inc_q && (dest_q == bix_pkg::DEST_WREG);
    assign file_we = inc_q && (dest_q != bix_pkg::DEST_WREG);
    assign wreg_wdata = sum;
    assign file_wdata = sum;
    assign file_waddr = addr_q;
    assign zero_we = inc_q;
    assign zero_flag = sum_zero;

    property p_branch_pc;
        @(posedge sys_clk) disable iff (!arst_n)
        is_branch |=> pc_load && pc_target[bix_pkg::LIT_W-1:0] ==
            $past(insn[bix_pkg::LIT_W-1:0]);
    endproperty
    a_branch_pc: assert property (p_branch_pc) else $error("branch literal not loaded");

    property p_branch_hi;
        @(posedge sys_clk) disable iff (!arst_n)
        is_branch |=> pc_target[bix_pkg::PC_W-1:bix_pkg::LIT_W] ==
            $past(program_counter_high_latch[bix_pkg::LATCH_HI_MSB:bix_pkg::LATCH_HI_LSB]);
    endproperty
    a_branch_hi: assert property (p_branch_hi) else $error("upper pc bits wrong");

    property p_branch_two;
        @(posedge sys_clk) disable iff (!arst_n)
        is_branch |=> flush && !is_branch && !is_inc ##1 !flush;
    endproperty
    a_branch_two: assert property (p_branch_two) else $error("branch not two cycles");

    property p_inc_sum;
        @(posedge sys_clk) disable iff (!arst_n)
        is_inc |=> sum == DATA_W'($past(file_rdata) + DATA_W'(1));
    endproperty
    a_inc_sum: assert property (p_inc_sum) else $error("increment result wrong");

    property p_inc_w;
        @(posedge sys_clk) disable iff (!arst_n)
        is_inc && !insn[bix_pkg::INC_DEST_BIT] |=> wreg_we && !file_we;
    endproperty
    a_inc_w: assert property (p_inc_w) else $error("dest 0 not to working reg");

    property p_inc_f;
        @(posedge sys_clk) disable iff (!arst_n)
        is_inc && insn[bix_pkg::INC_DEST_BIT] |=> file_we && !wreg_we &&
            file_waddr == $past(insn[bix_pkg::FADDR_W-1:0]);
    endproperty
    a_inc_f: assert property (p_inc_f) else $error("dest 1 not to file");

    property p_zero;
        @(posedge sys_clk) disable iff (!arst_n)
        is_inc |=> zero_we && zero_flag == ($past(file_rdata) == {DATA_W{1'b1}});
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_branch_flags;
        @(posedge sys_clk) disable iff (!arst_n)
        is_branch |=> !zero_we ##1 !zero_we;
    endproperty
    a_branch_flags: assert property (p_branch_flags) else $error("branch touched flags");

    // Port-level checks, apart from sum in p_sum_hold and p_wrap, so that a slip in the output wiring shows up too
    property p_flush_drop;
        @(posedge sys_clk) disable iff (!arst_n)
        flush |=> !pc_load && !zero_we && !wreg_we && !file_we;
    endproperty
    a_flush_drop: assert property (p_flush_drop) else $error("refill cycle not a no-op");

    property p_load_once;
        @(posedge sys_clk) disable iff (!arst_n)
        pc_load |-> flush ##1 (!pc_load && !flush);
    endproperty
    a_load_once: assert property (p_load_once) else $error("pc load not one cycle");

    property p_pc_hold;
        @(posedge sys_clk) disable iff (!arst_n)
        !is_branch |=> !pc_load && $stable(pc_target);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("pc changed without branch");

    property p_quiet;
        @(posedge sys_clk) disable iff (!arst_n)
        !is_inc |=> !zero_we && !wreg_we && !file_we;
    endproperty
    a_quiet: assert property (p_quiet) else $error("strobe without increment");

    property p_inc_wdata;
        @(posedge sys_clk) disable iff (!arst_n)
        is_inc && !insn[bix_pkg::INC_DEST_BIT] |=>
            wreg_wdata == DATA_W'($past(file_rdata) + DATA_W'(1));
    endproperty
    a_inc_wdata: assert property (p_inc_wdata) else $error("working reg data wrong");

    property p_inc_fdata;
        @(posedge sys_clk) disable iff (!arst_n)
        is_inc && insn[bix_pkg::INC_DEST_BIT] |=>
            file_wdata == DATA_W'($past(file_rdata) + DATA_W'(1));
    endproperty
    a_inc_fdata: assert property (p_inc_fdata) else $error("file write data wrong");

    property p_sum_hold;
        @(posedge sys_clk) disable iff (!arst_n)
        !is_inc |=> $stable(sum) && $stable(zero_flag);
    endproperty
    a_sum_hold: assert property (p_sum_hold) else $error("sum changed without increment");

    property p_wrap;
        @(posedge sys_clk) disable iff (!arst_n)
        is_inc && file_rdata == {DATA_W{1'b1}} |=>
            sum == {DATA_W{1'b0}} && zero_flag;
    endproperty
    a_wrap: assert property (p_wrap) else $error("all-ones did not wrap to zero");
endmodule
`default_nettype wire

// >>> bix_pkg.sv
// Package for the branch and increment execution block.
// Assumes a 14-bit instruction word and an 8-bit data path.
package bix_pkg;
    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int LIT_W = 11;
    localparam int FADDR_W = 7;
    // Opcode patterns
    localparam logic [2:0] BRANCH_OPC = 3'h5;
    localparam int BRANCH_OPC_MSB = 13;
    localparam int BRANCH_OPC_LSB = 11;
    localparam logic [5:0] INC_OPC = 6'h0A;
    localparam int INC_OPC_MSB = 13;
    localparam int INC_OPC_LSB = 8;
    localparam int INC_DEST_BIT = 7;
    // Latch bits that feed the upper program counter
    localparam int LATCH_HI_MSB = 4;
    localparam int LATCH_HI_LSB = 3;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic DEST_WREG = 1'b0;
    typedef enum logic [0:0] {BIX_EXEC, BIX_FLUSH} bix_state_t;
endpackage

// >>> bix_incr.sv
// Increment unit: registered sum and zero indication.
// Assumes operand is valid in the cycle load is high.
`timescale 1ns/1ps
`default_nettype none
module bix_incr #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk, // Core clock
    input wire logic arst_n, // Async reset
    input wire logic load, // Capture new sum
    input wire logic [WIDTH-1:0] operand, // Value read from file
    output logic [WIDTH-1:0] sum, // Registered sum
    output logic zero // Sum is zero
);
    logic [WIDTH-1:0] sum_q;
    logic [WIDTH-1:0] sum_d;
    logic zero_q;
    logic zero_d;

    if (WIDTH < 1) begin : g_width_check
        $error("bix_incr: WIDTH must be at least 1");
    end

    always_comb begin
        sum_d = sum_q;
        if (load) begin
            sum_d = operand + WIDTH'(1);
        end
        // Flag is registered alongside the sum so it stands with the data
        zero_d = (sum_d == '0);
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sum_q <= '0;
            zero_q <= 1'b1;
        end else begin
            sum_q <= sum_d;
            zero_q <= zero_d;
        end
    end

    assign sum = sum_q;
    assign zero = zero_q;
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the branch and increment execution block.
// Assumes bix_pkg and bix_exec are compiled first; assertions sit in the design.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic insn_valid = 1'b0;
    logic [13:0] insn = 14'h0000;
    logic [7:0] program_counter_high_latch = 8'h00;
    logic [7:0] file_rdata = 8'h00;
    logic [6:0] file_raddr, file_waddr;
    logic file_we, wreg_we, zero_we, zero_flag, pc_load, flush;
    logic [7:0] file_wdata, wreg_wdata;
    logic [12:0] pc_target;
    int errors = 0;
    int checks = 0;
    int cyc = 0;

    bix_exec bix_exec_i (
        .sys_clk, .arst_n, .insn_valid, .insn, .program_counter_high_latch, .file_rdata,
        .file_raddr, .file_we, .file_waddr, .file_wdata, .wreg_we, .wreg_wdata,
        .zero_we, .zero_flag, .pc_load, .pc_target, .flush
    );

    always #5 sys_clk = ~sys_clk;

    // Inputs change on the rising edge; results are judged at the falling edge
    task automatic step(input logic v, input logic [13:0] w, input logic [7:0] rd,
                        input logic [7:0] lat);
        @(posedge sys_clk);
        insn_valid <= v;
        insn <= w;
        file_rdata <= rd;
        program_counter_high_latch <= lat;
        @(negedge sys_clk);
    endtask

    function automatic logic [13:0] inc_word(input logic d, input logic [6:0] a);
        return {bix_pkg::INC_OPC, d, a};
    endfunction

    task automatic chk_inc(input logic d, input logic [6:0] a, input logic [7:0] rd);
        logic [7:0] s;
        s = rd + 8'h01;
        `CHK(wreg_we, ~d)
        `CHK(file_we, d)
        `CHK(d ? file_wdata : wreg_wdata, s)
        if (d) `CHK(file_waddr, a)
        `CHK(zero_we, 1'b1)
        `CHK(zero_flag, s == 8'h00)
        `CHK(pc_load, 1'b0)
    endtask

    // Branch, then an instruction offered in the refill cycle that must be dropped
    task automatic branch_test(input logic [7:0] lat, input logic [10:0] lit);
        step(1'b1, {bix_pkg::BRANCH_OPC, lit}, 8'h00, lat);
        step(1'b1, inc_word(1'b1, 7'h05), 8'hFF, ~lat);
        `CHK(pc_load, 1'b1)
        `CHK(pc_target[10:0], lit)
        `CHK(pc_target[12:11], lat[4:3])
        `CHK(flush, 1'b1)
        `CHK(zero_we, 1'b0)
        step(1'b0, 14'h0000, 8'h00, ~lat);
        `CHK(pc_load, 1'b0)
        `CHK(flush, 1'b0)
        `CHK(file_we | wreg_we | zero_we, 1'b0)
        `CHK(pc_target[12:11], lat[4:3])
        $display("TB: branch test done");
    endtask

    // Two increments back to back, working register first, then file register
    task automatic inc_pair(input logic [7:0] a_rd, input logic [7:0] b_rd);
        step(1'b1, inc_word(1'b0, 7'h15), a_rd, 8'hFF);
        `CHK(file_raddr, 7'h15)
        step(1'b1, inc_word(1'b1, 7'h7F), b_rd, 8'hFF);
        chk_inc(1'b0, 7'h15, a_rd);
        `CHK(file_raddr, 7'h7F)
        step(1'b0, 14'h0000, 8'h00, 8'hFF);
        chk_inc(1'b1, 7'h7F, b_rd);
        $display("TB: increment pair done");
    endtask

    // Valid low or an unknown opcode must leave every strobe and flush quiet and the pc held
    task automatic ignore_test();
        step(1'b0, inc_word(1'b1, 7'h22), 8'h10, 8'h18);
        step(1'b1, {3'h7, 11'h7FF}, 8'h10, 8'h18);
        `CHK(file_we | wreg_we | zero_we | pc_load, 1'b0)
        step(1'b1, {6'h0B, 1'b1, 7'h22}, 8'h10, 8'h18);
        `CHK(file_we | wreg_we | zero_we | pc_load, 1'b0)
        step(1'b0, 14'h0000, 8'h00, 8'h18);
        `CHK(file_we | wreg_we | zero_we | pc_load, 1'b0)
        `CHK(flush, 1'b0)
        `CHK(pc_target, 13'h0800)
        $display("TB: ignore test done");
    endtask

    // Increment straight before a branch: its flag strobe must not spill over
    task automatic inc_branch_test();
        step(1'b1, inc_word(1'b0, 7'h40), 8'hFF, 8'h10);
        step(1'b1, {bix_pkg::BRANCH_OPC, 11'h123}, 8'h00, 8'h10);
        chk_inc(1'b0, 7'h40, 8'hFF);
        step(1'b0, 14'h0000, 8'h00, 8'h00);
        `CHK(pc_load, 1'b1)
        `CHK(pc_target, 13'h1123)
        `CHK(zero_we | wreg_we | file_we, 1'b0)
        step(1'b0, 14'h0000, 8'h00, 8'h00);
        `CHK(flush | zero_we | pc_load, 1'b0)
        $display("TB: increment then branch done");
    endtask

    task automatic finish_test();
        $display("TB: %0d checks, %0d errors", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Whole run is about 43 cycles; cut a hang well beyond that
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            errors++;
            finish_test();
        end
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(negedge sys_clk);
        `CHK(pc_target, bix_pkg::PC_RESET)
        branch_test(8'h18, 11'h5A5);
        branch_test(8'hE7, 11'h7FF);
        branch_test(8'h08, 11'h000);
        inc_pair(8'h7F, 8'hFF);
        inc_pair(8'hFF, 8'h00);
        ignore_test();
        inc_branch_test();
        finish_test();
    end
endmodule
`default_nettype wire
